// File: hw/eeesr_pkg.sv
// Constants for the port 2 EEE status register bank
// How it works
// - Writable 100BASE-TX EEE advertisement bit 1, resets to one.
// - Advertisement bits 4, 3, 2 are read-only zero.
// - Wake error counter counts rising edges of wake timer done.
// - Counter resets to zero and saturates at all ones.
// - Reading the counter returns its value then clears it.
// - Bit 14 shows 100 Mb/s EEE enabled by next-page exchange.
// - Bit 13 latches transmit LPI until host writes one.
// - Bit 12 shows live transmit LPI.
// - Bit 11 latches receive LPI until host writes one.
// - Bit 10 shows live receive LPI.
// - Bit 6 reads fixed one: storage location indicated.
// - Bit 5 reads fixed one: next pages in dedicated store.
// - Bit 4 latches parallel detection fault, cleared by read.
// - Bit 3 shows link partner next-page ability.
// - Next-page exchange enable resets to one; clear skips EEE negotiation.
// - Bit 1 latches high on new received page.
package eeesr_pkg;
    // ------------------------------------------------------------
    // Register addresses (byte, word aligned)
    // ------------------------------------------------------------
    localparam logic [11:0] EEESR_ADDR_ADV = 12'h0ec;
    localparam logic [11:0] EEESR_ADDR_WEC = 12'h0ee;
    localparam logic [11:0] EEESR_ADDR_CS  = 12'h0f0;
    localparam logic [11:0] EEESR_ADDR_PCS = 12'h0f2;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EEESR_ADV_100TX   = 1;
    localparam int EEESR_ADV_1000KX  = 4;
    localparam int EEESR_ADV_10GT    = 3;
    localparam int EEESR_ADV_1000T   = 2;
    localparam int EEESR_CS_RSVD15   = 15;
    localparam int EEESR_CS_HW_EEE   = 14;
    localparam int EEESR_CS_TX_RCVD  = 13;
    localparam int EEESR_CS_TX_NOW   = 12;
    localparam int EEESR_CS_RX_RCVD  = 11;
    localparam int EEESR_CS_RX_NOW   = 10;
    localparam int EEESR_CS_RSVD_HI  = 9;
    localparam int EEESR_CS_RSVD_LO  = 8;
    localparam int EEESR_CS_LOC_ABLE = 6;
    localparam int EEESR_CS_LOC      = 5;
    localparam int EEESR_CS_PD_FAULT = 4;
    localparam int EEESR_CS_LP_NP    = 3;
    localparam int EEESR_CS_NP_ABLE  = 2;
    localparam int EEESR_CS_PAGE_RX  = 1;
    localparam int EEESR_CS_LP_AN    = 0;
    // Port 2 next-page enable sits in byte 0x0f3 bit 1
    localparam int EEESR_PCS_NP_EN   = 9;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam int          EEESR_WEC_W       = 16;
    localparam logic [15:0] EEESR_WEC_RST     = 16'h0000;
    localparam logic [15:0] EEESR_WEC_MAX     = 16'hffff;
    localparam logic [15:0] EEESR_WEC_ONE     = 16'h0001;
    localparam logic        EEESR_ADV_RST     = 1'b1;
    localparam logic        EEESR_NP_EN_RST   = 1'b1;
    localparam logic        EEESR_RSVD15_RST  = 1'b1;
    localparam logic [1:0]  EEESR_RSVD98_RST  = 2'h0;
    localparam logic        EEESR_FIXED_ONE   = 1'b1;
    localparam logic [15:0] EEESR_ZERO        = 16'h0000;
endpackage : eeesr_pkg

// File: hw/eeesr_cnt_if.sv
// Link between the register bank and its wake error counter
`timescale 1ns/10ps
interface eeesr_cnt_if;
    logic        clr;
    logic        inc;
    logic [15:0] count;
    modport owner (input clr, input inc, output count);
    modport user  (output clr, output inc, input count);
endinterface : eeesr_cnt_if

// File: hw/eeesr_wake_cnt.sv
// Saturating, clear-on-read wake error counter
`timescale 1ns/10ps
module eeesr_wake_cnt
    import eeesr_pkg::*;
(
    // Clock and reset
    input wire logic  i_clk,
    input wire logic  i_srst,
    // Counter link
    eeesr_cnt_if.owner cnt
);
    logic [EEESR_WEC_W-1:0] cnt_q;
    logic [EEESR_WEC_W-1:0] cnt_d;

    // ------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (cnt.clr) begin
            cnt_d = EEESR_WEC_RST;
        end
        if (cnt.inc) begin
            if (cnt.clr) begin
                cnt_d = EEESR_WEC_ONE;
            end else if (cnt_q != EEESR_WEC_MAX) begin
                cnt_d = cnt_q + EEESR_WEC_ONE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q <= EEESR_WEC_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign cnt.count = cnt_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wec_inc;
        @(posedge i_clk) disable iff (i_srst)
        cnt.inc && !cnt.clr && cnt_q != EEESR_WEC_MAX
            |=> cnt_q == $past(cnt_q) + EEESR_WEC_ONE;
    endproperty
    a_wec_inc: assert property (p_wec_inc)
        else $error("wake count did not step");

    property p_wec_sat;
        @(posedge i_clk) disable iff (i_srst)
        cnt_q == EEESR_WEC_MAX && !cnt.clr |=> cnt_q == EEESR_WEC_MAX;
    endproperty
    a_wec_sat: assert property (p_wec_sat)
        else $error("wake count wrapped");

    property p_wec_clr_inc;
        @(posedge i_clk) disable iff (i_srst)
        cnt.clr |=> cnt_q == {15'h0000, $past(cnt.inc)};
    endproperty
    a_wec_clr_inc: assert property (p_wec_clr_inc)
        else $error("clearing read lost or kept count");

    c_wec_sat: cover property (@(posedge i_clk) disable iff (i_srst)
        cnt_q == EEESR_WEC_MAX && cnt.inc);
endmodule : eeesr_wake_cnt

// File: hw/eeesr_top.sv
// Port 2 EEE advertisement, wake error count and control/status bank
`timescale 1ns/10ps
module eeesr_top
    import eeesr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Host register port
    input  wire logic [11:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [1:0]  i_be,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    // PHY status
    input  wire logic        i_wake_timer_done,
    input  wire logic        i_hw_eee_en,
    input  wire logic        i_tx_lpi,
    input  wire logic        i_rx_lpi,
    input  wire logic        i_par_det_fault,
    input  wire logic        i_lp_np_able,
    input  wire logic        i_page_rcvd,
    input  wire logic        i_lp_an_able,
    // PHY control
    output logic             o_adv_100tx_eee,
    output logic             o_np_exchange_en
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a[11:1] == r[11:1]);
    endfunction : hit

    logic wr_lo_adv;
    logic wr_hi_cs;
    logic wr_hi_pcs;
    logic rd_cs;
    logic rd_wec;

    assign wr_lo_adv = i_wr && i_be[0] && hit(i_addr, EEESR_ADDR_ADV);
    assign wr_hi_cs  = i_wr && i_be[1] && hit(i_addr, EEESR_ADDR_CS);
    assign wr_hi_pcs = i_wr && i_be[1] && hit(i_addr, EEESR_ADDR_PCS);
    assign rd_cs     = i_rd && hit(i_addr, EEESR_ADDR_CS);
    assign rd_wec    = i_rd && hit(i_addr, EEESR_ADDR_WEC);

    // ------------------------------------------------------------
    // Wake error counter
    // ------------------------------------------------------------
    eeesr_cnt_if cnt_if ();
    logic done_q;
    logic done_d;

    assign done_d = i_wake_timer_done;
    assign cnt_if.inc = i_wake_timer_done && !done_q;
    assign cnt_if.clr = rd_wec;

    eeesr_wake_cnt u_wake_cnt (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .cnt    (cnt_if)
    );

    // ------------------------------------------------------------
    // Control and status state
    // ------------------------------------------------------------
    logic       adv_q,     adv_d;
    logic       np_en_q,   np_en_d;
    logic       rsvd15_q,  rsvd15_d;
    logic [1:0] rsvd98_q,  rsvd98_d;
    logic       tx_rcvd_q, tx_rcvd_d;
    logic       rx_rcvd_q, rx_rcvd_d;
    logic       pd_q,      pd_d;
    logic       page_q,    page_d;

    always_comb begin
        adv_d    = adv_q;
        np_en_d  = np_en_q;
        rsvd15_d = rsvd15_q;
        rsvd98_d = rsvd98_q;
        if (wr_lo_adv) begin
            adv_d = i_wdata[EEESR_ADV_100TX];
        end
        if (wr_hi_pcs) begin
            np_en_d = i_wdata[EEESR_PCS_NP_EN];
        end
        if (wr_hi_cs) begin
            rsvd15_d = i_wdata[EEESR_CS_RSVD15];
            rsvd98_d = i_wdata[EEESR_CS_RSVD_HI:EEESR_CS_RSVD_LO];
        end
        tx_rcvd_d = i_tx_lpi
            || (tx_rcvd_q && !(wr_hi_cs && i_wdata[EEESR_CS_TX_RCVD]));
        rx_rcvd_d = i_rx_lpi
            || (rx_rcvd_q && !(wr_hi_cs && i_wdata[EEESR_CS_RX_RCVD]));
        pd_d = i_par_det_fault || (pd_q && !rd_cs);
        // latch new page, clear on read
        page_d = i_page_rcvd || (page_q && !rd_cs);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            adv_q     <= EEESR_ADV_RST;
            np_en_q   <= EEESR_NP_EN_RST;
            rsvd15_q  <= EEESR_RSVD15_RST;
            rsvd98_q  <= EEESR_RSVD98_RST;
            tx_rcvd_q <= 1'b0;
            rx_rcvd_q <= 1'b0;
            pd_q      <= 1'b0;
            page_q    <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            adv_q     <= adv_d;
            np_en_q   <= np_en_d;
            rsvd15_q  <= rsvd15_d;
            rsvd98_q  <= rsvd98_d;
            tx_rcvd_q <= tx_rcvd_d;
            rx_rcvd_q <= rx_rcvd_d;
            pd_q      <= pd_d;
            page_q    <= page_d;
            done_q    <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] rd_word;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic        rvalid_q;

    always_comb begin
        rd_word = EEESR_ZERO;
        if (hit(i_addr, EEESR_ADDR_ADV)) begin
            rd_word[EEESR_ADV_1000KX] = 1'b0;
            rd_word[EEESR_ADV_10GT]   = 1'b0;
            rd_word[EEESR_ADV_1000T]  = 1'b0;
            rd_word[EEESR_ADV_100TX]  = adv_q;
        end else if (hit(i_addr, EEESR_ADDR_WEC)) begin
            rd_word = cnt_if.count;
        end else if (hit(i_addr, EEESR_ADDR_CS)) begin
            rd_word[EEESR_CS_RSVD15] = rsvd15_q;
            rd_word[EEESR_CS_HW_EEE] = i_hw_eee_en && np_en_q;
            rd_word[EEESR_CS_TX_RCVD] = tx_rcvd_q;
            rd_word[EEESR_CS_TX_NOW] = i_tx_lpi;
            rd_word[EEESR_CS_RX_RCVD] = rx_rcvd_q;
            rd_word[EEESR_CS_RX_NOW] = i_rx_lpi;
            rd_word[EEESR_CS_RSVD_HI:EEESR_CS_RSVD_LO] = rsvd98_q;
            rd_word[EEESR_CS_LOC_ABLE] = EEESR_FIXED_ONE;
            rd_word[EEESR_CS_LOC]      = EEESR_FIXED_ONE;
            rd_word[EEESR_CS_PD_FAULT] = pd_q;
            rd_word[EEESR_CS_LP_NP]    = i_lp_np_able;
            rd_word[EEESR_CS_NP_ABLE]  = EEESR_FIXED_ONE;
            rd_word[EEESR_CS_PAGE_RX]  = page_q;
            rd_word[EEESR_CS_LP_AN]    = i_lp_an_able;
        end else if (hit(i_addr, EEESR_ADDR_PCS)) begin
            rd_word[EEESR_PCS_NP_EN] = np_en_q;
        end
        // Hold last data between reads
        rdata_d = i_rd ? rd_word : rdata_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_q  <= EEESR_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= i_rd;
        end
    end

    assign o_rdata          = rdata_q;
    assign o_rvalid         = rvalid_q;
    assign o_adv_100tx_eee  = adv_q;
    // clearing this is how EEE is turned off
    assign o_np_exchange_en = np_en_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_adv_ro;
        @(posedge i_clk) disable iff (i_srst)
        i_rd && hit(i_addr, EEESR_ADDR_ADV) |=> o_rvalid
            && o_rdata[4:2] == 3'h0 && o_rdata[1] == $past(adv_q);
    endproperty
    a_adv_ro: assert property (p_adv_ro)
        else $error("advertisement readback wrong");

    property p_wec_read;
        @(posedge i_clk) disable iff (i_srst)
        rd_wec && !cnt_if.inc |=> o_rdata == $past(cnt_if.count)
            && cnt_if.count == EEESR_WEC_RST;
    endproperty
    a_wec_read: assert property (p_wec_read)
        else $error("counter read did not return then clear");

    property p_tx_hold;
        @(posedge i_clk) disable iff (i_srst)
        i_tx_lpi ##1 !(wr_hi_cs && i_wdata[EEESR_CS_TX_RCVD])[*2]
            |=> tx_rcvd_q;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx lpi latch dropped");

    property p_rx_clr;
        @(posedge i_clk) disable iff (i_srst)
        wr_hi_cs && i_wdata[EEESR_CS_RX_RCVD] && !i_rx_lpi |=> !rx_rcvd_q;
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("rx lpi latch not cleared");

    property p_live;
        @(posedge i_clk) disable iff (i_srst)
        rd_cs |=> o_rdata[12] == $past(i_tx_lpi)
            && o_rdata[10] == $past(i_rx_lpi) && o_rdata[6:5] == 2'h3;
    endproperty
    a_live: assert property (p_live)
        else $error("live lpi or fixed bits wrong");

    property p_pd_rc;
        @(posedge i_clk) disable iff (i_srst)
        pd_q && rd_cs && !i_par_det_fault ##1 !i_par_det_fault
            |-> !pd_q ##1 !pd_q;
    endproperty
    a_pd_rc: assert property (p_pd_rc)
        else $error("fault bit not cleared by read");

    property p_page;
        @(posedge i_clk) disable iff (i_srst)
        i_page_rcvd |=> page_q;
    endproperty
    a_page: assert property (p_page)
        else $error("page received not latched");

    property p_hw_eee;
        @(posedge i_clk) disable iff (i_srst)
        rd_cs && !np_en_q |=> !o_rdata[14];
    endproperty
    a_hw_eee: assert property (p_hw_eee)
        else $error("eee status set with next page off");

    c_tx_clr: cover property (@(posedge i_clk) disable iff (i_srst)
        tx_rcvd_q ##1 !tx_rcvd_q);
    c_wec_rd: cover property (@(posedge i_clk) disable iff (i_srst)
        rd_wec && cnt_if.inc);
    c_np_off: cover property (@(posedge i_clk) disable iff (i_srst)
        np_en_q ##1 !np_en_q);
endmodule : eeesr_top

// File: dv/eeesr_phy_model.sv
// Behavioural PHY side feeding status levels into the register bank
`timescale 1ns/10ps
module eeesr_phy_model (
    // Clock and bench command
    input  wire logic       i_clk,
    input  wire logic [7:0] i_cmd,
    // Status levels toward the bank
    output logic            o_wake_timer_done,
    output logic            o_hw_eee_en,
    output logic            o_tx_lpi,
    output logic            o_rx_lpi,
    output logic            o_par_det_fault,
    output logic            o_lp_np_able,
    output logic            o_page_rcvd,
    output logic            o_lp_an_able
);
    // -----------------------------------------------------------------
    // One register stage, as a PHY status path would add
    // -----------------------------------------------------------------
    logic [7:0] lvl_q;

    always_ff @(posedge i_clk) begin
        lvl_q <= i_cmd;
    end

    assign o_wake_timer_done = lvl_q[0];
    assign o_hw_eee_en       = lvl_q[1];
    assign o_tx_lpi          = lvl_q[2];
    assign o_rx_lpi          = lvl_q[3];
    assign o_par_det_fault   = lvl_q[4];
    assign o_lp_np_able      = lvl_q[5];
    assign o_page_rcvd       = lvl_q[6];
    assign o_lp_an_able      = lvl_q[7];
endmodule : eeesr_phy_model

// File: dv/test_eee_status_register_bank.sv
// Self-checking bench for the port 2 EEE status register bank
`timescale 1ns/10ps
module test_eee_status_register_bank;
    import eeesr_pkg::*;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    localparam logic [15:0] CS_BASE = 16'h8064;
    logic        i_clk   = 1'b0;
    logic        i_srst  = 1'b1;
    logic [11:0] i_addr  = 12'h000;
    logic        i_rd    = 1'b0;
    logic        i_wr    = 1'b0;
    logic [1:0]  i_be    = 2'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [7:0]  cmd     = 8'h00;
    logic [15:0] o_rdata;
    logic        o_rvalid;
    logic        o_adv;
    logic        o_np;
    wire  [7:0]  phy;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    always #12.5 i_clk = ~i_clk;

    eeesr_phy_model PHY (
        .i_clk(i_clk), .i_cmd(cmd),
        .o_wake_timer_done(phy[0]), .o_hw_eee_en(phy[1]),
        .o_tx_lpi(phy[2]), .o_rx_lpi(phy[3]), .o_par_det_fault(phy[4]),
        .o_lp_np_able(phy[5]), .o_page_rcvd(phy[6]), .o_lp_an_able(phy[7])
    );

    eeesr_top DUT (
        .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_rd(i_rd),
        .i_wr(i_wr), .i_be(i_be), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .i_wake_timer_done(phy[0]),
        .i_hw_eee_en(phy[1]), .i_tx_lpi(phy[2]), .i_rx_lpi(phy[3]),
        .i_par_det_fault(phy[4]), .i_lp_np_able(phy[5]),
        .i_page_rcvd(phy[6]), .i_lp_an_able(phy[7]),
        .o_adv_100tx_eee(o_adv), .o_np_exchange_en(o_np)
    );
    // -----------------------------------------------------------------
    // Tasks; all drive changes land 1 ns after a rising edge
    // -----------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    // Gap cycle after each access keeps a strobe from toggling twice
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        i_addr = a;
        i_rd   = 1'b1;
        tick(1);
        i_rd   = 1'b0;
        chk({15'h0000, o_rvalid}, 16'h0001);
        chk(o_rdata, exp);
        tick(1);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        i_addr  = a;
        i_be    = be;
        i_wdata = d;
        i_wr    = 1'b1;
        tick(1);
        i_wr    = 1'b0;
        tick(1);
    endtask : wr

    // Two cycles high gives exactly one rising edge at the bank
    task automatic pulse(input int b);
        cmd[b] = 1'b1;
        tick(2);
        cmd[b] = 1'b0;
        tick(3);
    endtask : pulse

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        tick(10);
        i_srst = 1'b0;
        chk({14'h0000, o_adv, o_np}, 16'h0003);
        rd(EEESR_ADDR_ADV, 16'h0002);
        rd(EEESR_ADDR_WEC, EEESR_WEC_RST);
        rd(EEESR_ADDR_CS, CS_BASE);
        rd(EEESR_ADDR_PCS, 16'h0200);
        rd(12'h0f8, 16'h0000);
        wr(EEESR_ADDR_ADV, 2'h3, 16'hffff);
        rd(EEESR_ADDR_ADV, 16'h0002);
        wr(EEESR_ADDR_ADV, 2'h3, 16'h0000);
        rd(EEESR_ADDR_ADV, 16'h0000);
        chk({15'h0000, o_adv}, 16'h0000);
        wr(EEESR_ADDR_ADV, 2'h1, 16'h0002);
        rd(EEESR_ADDR_ADV, 16'h0002);
        // Saturation needs 64K edges, beyond this run's cycle budget
        for (int k = 0; k < 3; k++) begin
            pulse(0);
        end
        rd(EEESR_ADDR_WEC, 16'h0003);
        rd(EEESR_ADDR_WEC, 16'h0000);
        pulse(0);
        cmd[0] = 1'b1;
        tick(1);
        rd(EEESR_ADDR_WEC, 16'h0001);
        cmd[0] = 1'b0;
        tick(3);
        rd(EEESR_ADDR_WEC, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            cmd[2+k] = 1'b1;
            tick(3);
            rd(EEESR_ADDR_CS, CS_BASE | (16'h3000 >> (2*k)));
            cmd[2+k] = 1'b0;
            tick(3);
            rd(EEESR_ADDR_CS, CS_BASE | (16'h2000 >> (2*k)));
            wr(EEESR_ADDR_CS, 2'h2, CS_BASE | (16'h2000 >> (2*k)));
            rd(EEESR_ADDR_CS, CS_BASE);
        end
        for (int k = 0; k < 2; k++) begin
            pulse(4 + 2*k);
            rd(EEESR_ADDR_CS, CS_BASE | (16'h0010 >> (3*k)));
            rd(EEESR_ADDR_CS, CS_BASE);
        end
        cmd[5] = 1'b1;
        cmd[7] = 1'b1;
        tick(2);
        rd(EEESR_ADDR_CS, CS_BASE | 16'h0009);
        cmd[5] = 1'b0;
        cmd[7] = 1'b0;
        wr(EEESR_ADDR_CS, 2'h2, 16'h0300);
        rd(EEESR_ADDR_CS, 16'h0364);
        wr(EEESR_ADDR_CS, 2'h2, 16'h8000);
        cmd[1] = 1'b1;
        tick(2);
        rd(EEESR_ADDR_CS, CS_BASE | 16'h4000);
        // Software turns EEE off through the next-page enable
        wr(EEESR_ADDR_PCS, 2'h2, 16'h0000);
        rd(EEESR_ADDR_PCS, 16'h0000);
        chk({15'h0000, o_np}, 16'h0000);
        rd(EEESR_ADDR_CS, CS_BASE);
        cmd[1] = 1'b0;
        // Upper lane alone must not touch the advertisement bit
        wr(EEESR_ADDR_ADV, 2'h2, 16'h0000);
        rd(EEESR_ADDR_ADV, 16'h0002);
        // Leave non-default state behind so reset has work to do
        wr(EEESR_ADDR_ADV, 2'h1, 16'h0000);
        pulse(0);
        // Second reset in mid-run restores defaults
        i_srst = 1'b1;
        tick(2);
        i_srst = 1'b0;
        chk({14'h0000, o_adv, o_np}, 16'h0003);
        rd(EEESR_ADDR_WEC, EEESR_WEC_RST);
        rd(EEESR_ADDR_PCS, 16'h0200);
        stop_test();
    end
endmodule : test_eee_status_register_bank
